/* hdl/tg_ctrl_pkg.sv */
`default_nettype none
package tg_ctrl_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int STATE_W = 4;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 16'h000F;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;
    localparam logic [DATA_W-1:0] SEED_RESET = 32'h1234_5678;
    localparam logic [DATA_W-1:0] SEED_STEP = 32'h9E37_79B9;

    typedef enum logic [STATE_W-1:0] {
        state_start = 4'h0,
        state_load = 4'h1,
        state_write = 4'h2,
        state_read = 4'h3,
        state_done = 4'h4,
        state_held = 4'h5,
        state_retest = 4'h6,
        state_error_stopped = 4'h7
    } gen_state_type;
endpackage : tg_ctrl_pkg
`default_nettype wire

/* hdl/tg_link_if.sv */
`default_nettype none
interface tg_link_if;
    import tg_ctrl_pkg::*;
    // Request stream from generator to memory side
    logic req_valid;
    logic req_ready;
    logic req_write;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_data;
    // Read return stream
    logic rsp_valid;
    logic rsp_ready;
    logic [DATA_W-1:0] rsp_data;

    modport gen(output req_valid, req_write, req_addr, req_data, rsp_ready,
                input req_ready, rsp_valid, rsp_data);
    modport mem(input req_valid, req_write, req_addr, req_data, rsp_ready,
                output req_ready, rsp_valid, rsp_data);
endinterface : tg_link_if
`default_nettype wire

/* hdl/tg_fifo.sv */
`default_nettype none
module tg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 2");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW:0] wr_q;
    logic [PW:0] rd_q;
    logic push;
    logic pop;
    assign in_ready = (wr_q - rd_q) != (PW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q[PW-1:0]];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q[PW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : tg_fifo
`default_nettype wire

/* hdl/tg_mem_end.sv */
`default_nettype none
module tg_mem_end
    import tg_ctrl_pkg::*;
#(
    parameter int WORDS = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Link
    tg_link_if.mem link,
    // Fault injection and stall for debug
    input wire logic flip_read_bit,
    input wire logic stall
);
    if (WORDS < 2 || $clog2(WORDS) > ADDR_W) begin : g_bad_words
        $error("WORDS must be at least 2 and fit the address");
    end
    logic [DATA_W-1:0] store_q [WORDS];
    logic rsp_valid_q;
    logic [DATA_W-1:0] rsp_data_q;
    logic [$clog2(WORDS)-1:0] idx;
    assign idx = link.req_addr[$clog2(WORDS)-1:0];
    assign link.req_ready = !stall && (!rsp_valid_q || link.rsp_ready);
    assign link.rsp_valid = rsp_valid_q;
    assign link.rsp_data = rsp_data_q;

    always_ff @(posedge ref_clk) begin
        if (link.req_valid && link.req_ready && link.req_write) begin
            store_q[idx] <= link.req_data;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= '0;
        end else if (link.req_valid && link.req_ready && !link.req_write) begin
            rsp_valid_q <= 1'b1;
            rsp_data_q <= store_q[idx] ^ {{(DATA_W-1){1'b0}}, flip_read_bit};
        end else if (link.rsp_ready) begin
            rsp_valid_q <= 1'b0;
        end
    end
endmodule : tg_mem_end
`default_nettype wire

/* hdl/tg_gen_end.sv */
`default_nettype none
module tg_gen_end
    import tg_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control probes
    input wire logic calib_done,
    input wire logic run_gate,
    input wire logic gen_sync_reset,
    input wire logic gen_rerun,
    input wire logic gen_hold,
    input wire logic stop_on_mismatch_en,
    input wire logic mismatch_clear_nonsticky,
    input wire logic mismatch_clear_all,
    input wire logic resume_after_mismatch,
    // Status
    output logic [STATE_W-1:0] gen_state_out,
    output logic mismatch_q,
    output logic sticky_mismatch_q,
    output logic read_error_q,
    output logic write_error_q,
    output logic [ADDR_W-1:0] fail_addr_q,
    output logic [DATA_W-1:0] expected_q,
    output logic [DATA_W-1:0] actual_q,
    // Link
    tg_link_if.gen link
);
    // ==========================================================
    // Input sampling
    logic [8:0] in_s1_q;
    logic [8:0] in_s2_q;
    logic [2:0] edge_prev_q;
    logic clr_rise;
    logic all_rise;
    logic cont_rise;
    logic sreset;
    logic s_calib;
    logic s_gate;
    logic s_rerun;
    logic s_hold;
    logic s_chk;
    always_ff @(posedge ref_clk) begin
        in_s1_q <= {calib_done, run_gate, gen_sync_reset, gen_rerun, gen_hold,
            stop_on_mismatch_en, mismatch_clear_nonsticky, mismatch_clear_all,
            resume_after_mismatch};
        in_s2_q <= in_s1_q;
        edge_prev_q <= in_s2_q[2:0];
    end
    assign {s_calib, s_gate, sreset, s_rerun, s_hold, s_chk} = in_s2_q[8:3];
    assign clr_rise = in_s2_q[2] && !edge_prev_q[2];
    assign all_rise = in_s2_q[1] && !edge_prev_q[1];
    assign cont_rise = in_s2_q[0] && !edge_prev_q[0];

    // ==========================================================
    // Data path: FIFO of issued read addresses, and memory of expected data
    gen_state_type state_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] pat_q;
    logic [DATA_W-1:0] exp_mem_q [1 << ADDR_W];
    logic f_in_valid;
    logic f_in_ready;
    logic [ADDR_W:0] f_out_data;
    logic [ADDR_W-1:0] ret_addr;
    logic issuing;
    logic fire;
    logic rsp_fire;
    logic bad;
    logic do_reset;
    assign do_reset = rst || sreset;
    assign issuing = (state_q == state_write || state_q == state_read
        || state_q == state_retest) && !s_hold;
    assign link.req_valid = issuing && f_in_ready;
    assign link.req_write = state_q == state_write;
    assign link.req_addr = addr_q;
    assign link.req_data = pat_q;
    assign fire = link.req_valid && link.req_ready;
    assign f_in_valid = fire && !link.req_write;
    assign ret_addr = f_out_data[ADDR_W-1:0];
    assign rsp_fire = link.rsp_valid && link.rsp_ready;
    assign bad = rsp_fire && link.rsp_data != exp_mem_q[ret_addr];
    assign gen_state_out = state_q;

    tg_fifo #(.WIDTH(ADDR_W + 1), .DEPTH(FIFO_DEPTH)) pend_fifo (
        .ref_clk(ref_clk),
        .rst(do_reset),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data({state_q == state_retest, addr_q}),
        .out_valid(),
        .out_ready(rsp_fire),
        .out_data(f_out_data)
    );
    assign link.rsp_ready = 1'b1;

    always_ff @(posedge ref_clk) begin
        if (fire && link.req_write) begin
            exp_mem_q[addr_q] <= pat_q;
        end
    end

    // ==========================================================
    // Sequencer
    logic last;
    assign last = addr_q == LAST_ADDR;
    always_ff @(posedge ref_clk) begin
        if (do_reset) begin
            state_q <= state_start;
            addr_q <= '0;
            pat_q <= SEED_RESET;
        end else begin
            case (state_q)
                state_start: begin
                    if (s_calib && s_gate) begin
                        state_q <= state_load;
                    end
                end
                state_load: begin
                    addr_q <= '0;
                    // A restart replays the same pattern from the seed
                    pat_q <= SEED_RESET;
                    state_q <= state_write;
                end
                state_write: begin
                    if (s_hold) begin
                        state_q <= state_held;
                    end else if (fire) begin
                        pat_q <= pat_q + SEED_STEP;
                        addr_q <= last ? '0 : addr_q + ADDR_STEP;
                        if (last) begin
                            state_q <= state_read;
                        end
                    end
                end
                state_read: begin
                    if (bad && s_chk) begin
                        state_q <= state_retest;
                        addr_q <= ret_addr;
                    end else if (s_hold) begin
                        state_q <= state_held;
                    end else if (fire) begin
                        addr_q <= last ? '0 : addr_q + ADDR_STEP;
                        if (last) begin
                            state_q <= state_done;
                        end
                    end
                end
                state_retest: begin
                    if (rsp_fire && f_out_data[ADDR_W]) begin
                        state_q <= state_error_stopped;
                    end else if (fire) begin
                        state_q <= state_retest;
                    end
                end
                state_error_stopped: begin
                    if (s_rerun) begin
                        state_q <= state_load;
                    end else if (cont_rise) begin
                        state_q <= state_read;
                        addr_q <= last ? '0 : addr_q + ADDR_STEP;
                    end
                end
                state_held: begin
                    if (s_rerun) begin
                        state_q <= state_load;
                    end else if (!s_hold) begin
                        state_q <= state_read;
                    end
                end
                state_done: begin
                    if (s_rerun) begin
                        state_q <= state_load;
                    end
                end
                default: begin
                    state_q <= state_start;
                end
            endcase
        end
    end

    // ==========================================================
    // Error capture
    logic retest_done;
    assign retest_done = rsp_fire && f_out_data[ADDR_W]
        && state_q == state_retest;
    // A new mismatch wins over either clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (do_reset) begin
            mismatch_q <= 1'b0;
            sticky_mismatch_q <= 1'b0;
            fail_addr_q <= '0;
            expected_q <= '0;
            actual_q <= '0;
        end else if (bad && !f_out_data[ADDR_W]) begin
            mismatch_q <= 1'b1;
            sticky_mismatch_q <= 1'b1;
            if (!mismatch_q) begin
                fail_addr_q <= ret_addr;
                expected_q <= exp_mem_q[ret_addr];
                actual_q <= link.rsp_data;
            end
        end else if (clr_rise || all_rise) begin
            mismatch_q <= 1'b0;
            fail_addr_q <= '0;
            expected_q <= '0;
            actual_q <= '0;
            if (all_rise) begin
                sticky_mismatch_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (do_reset) begin
            read_error_q <= 1'b0;
            write_error_q <= 1'b0;
        end else if (retest_done) begin
            read_error_q <= !bad;
            write_error_q <= bad;
        end else if (clr_rise || all_rise) begin
            read_error_q <= 1'b0;
            write_error_q <= 1'b0;
        end
    end
endmodule : tg_gen_end
`default_nettype wire

/* bench/tg_link_sva.sv */
`default_nettype none
module tg_link_sva
    import tg_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Request stream
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_data,
    // Read return stream
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic [DATA_W-1:0] rsp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Helpers
    logic wr_take;
    logic rd_take;
    logic [ADDR_W-1:0] last_wr_q;
    assign wr_take = req_valid && req_ready && req_write;
    assign rd_take = req_valid && req_ready && !req_write;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_wr_q <= '0;
        end else if (wr_take) begin
            last_wr_q <= req_addr;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Properties
    chk_reset_idle: assert property (
        @(posedge ref_clk) disable iff (1'b0) rst |=> !req_valid)
        else $error("request during reset");
    chk_req_holds: assert property (
        req_valid && !req_ready |=> req_valid && $stable(req_addr)
        && $stable(req_write) && $stable(req_data))
        else $error("request changed before taken");
    chk_rsp_timing: assert property (rd_take |=> rsp_valid)
        else $error("read answer late");
    chk_rsp_cause: assert property (rsp_valid |-> $past(rd_take))
        else $error("answer without read");
    chk_read_order: assert property (
        rd_take |-> !$past(wr_take) || $past(req_addr) == LAST_ADDR)
        else $error("read pass began before last write");
    chk_write_order: assert property (
        wr_take |-> req_addr == '0 || req_addr == last_wr_q + ADDR_STEP)
        else $error("write address out of order");
    chk_write_range: assert property (
        wr_take |-> req_addr <= LAST_ADDR)
        else $error("write address out of range");
    chk_read_range: assert property (
        rd_take |-> req_addr <= LAST_ADDR)
        else $error("read address out of range");
endmodule : tg_link_sva
`default_nettype wire

/* bench/memory_traffic_gen_control_test.sv */
`default_nettype none
module memory_traffic_gen_control_test
    import tg_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, calib_done, run_gate, gen_sync_reset, gen_rerun;
    logic gen_hold, stop_on_mismatch_en, clr_ns, clr_all, resume, flip, stall;
    logic [STATE_W-1:0] st;
    logic mm, sticky, rd_err, wr_err;
    logic [ADDR_W-1:0] f_addr;
    logic [DATA_W-1:0] exp_d, act_d;
    int fail_count = 0;
    int samples_checked = 0;
    tg_link_if i_tg_link_if();
    tg_gen_end i_tg_gen_end(.ref_clk(ref_clk), .rst(rst),
        .calib_done(calib_done), .run_gate(run_gate),
        .gen_sync_reset(gen_sync_reset), .gen_rerun(gen_rerun),
        .gen_hold(gen_hold), .stop_on_mismatch_en(stop_on_mismatch_en),
        .mismatch_clear_nonsticky(clr_ns), .mismatch_clear_all(clr_all),
        .resume_after_mismatch(resume), .gen_state_out(st),
        .mismatch_q(mm), .sticky_mismatch_q(sticky), .read_error_q(rd_err),
        .write_error_q(wr_err), .fail_addr_q(f_addr), .expected_q(exp_d),
        .actual_q(act_d), .link(i_tg_link_if.gen));
    tg_mem_end #(.WORDS(16)) i_tg_mem_end(.ref_clk(ref_clk), .rst(rst),
        .link(i_tg_link_if.mem), .flip_read_bit(flip), .stall(stall));
    tg_link_sva i_tg_link_sva(.ref_clk(ref_clk), .rst(rst),
        .req_valid(i_tg_link_if.req_valid),
        .req_ready(i_tg_link_if.req_ready),
        .req_write(i_tg_link_if.req_write), .req_addr(i_tg_link_if.req_addr),
        .req_data(i_tg_link_if.req_data), .rsp_valid(i_tg_link_if.rsp_valid),
        .rsp_ready(i_tg_link_if.rsp_ready), .rsp_data(i_tg_link_if.rsp_data));
    // ==========================================================
    // Shared tasks
    task automatic check(input string name, input logic [31:0] e,
                         input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask : check
    task automatic wait_state(input gen_state_type s, input int max);
        int n;
        n = 0;
        while (st !== s && n < max) begin
            @(negedge ref_clk);
            n++;
        end
        check("gen_state_out", s, st);
    endtask : wait_state
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic stop_test();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic rerun();
        gen_rerun = 1'b1;
        wait_state(state_write, 12);
        gen_rerun = 1'b0;
    endtask : rerun
    // ==========================================================
    // Scenarios
    task automatic t_gate_and_pass();
        calib_done = 1'b1;
        cyc(20);
        check("gen_state_out", state_start, st);
        run_gate = 1'b1;
        wait_state(state_write, 10);
        stall = 1'b1;
        cyc(20);
        check("req_valid", 1, i_tg_link_if.req_valid);
        stall = 1'b0;
        wait_state(state_done, 200);
        // The last read is still being compared when done shows
        cyc(2);
        check("mismatch_q", 0, mm);
    endtask : t_gate_and_pass
    task automatic t_hold();
        rerun();
        gen_hold = 1'b1;
        cyc(4);
        check("gen_state_out", state_held, st);
        repeat (8) begin
            cyc(1);
            check("req_valid", 0, i_tg_link_if.req_valid);
        end
        gen_hold = 1'b0;
        wait_state(state_done, 200);
    endtask : t_hold
    task automatic t_stop_and_clear();
        flip = 1'b1;
        stop_on_mismatch_en = 1'b1;
        rerun();
        wait_state(state_error_stopped, 300);
        check("write_error_q", 1, wr_err);
        check("read_error_q", 0, rd_err);
        check("fail_addr_q", 0, f_addr);
        check("expected_q", SEED_RESET, exp_d);
        check("actual_q", SEED_RESET ^ 32'h0000_0001, act_d);
        check("sticky", 1, sticky);
        clr_ns = 1'b1;
        cyc(5);
        clr_ns = 1'b0;
        check("mismatch_q", 0, mm);
        check("write_error_q", 0, wr_err);
        check("expected_q", 0, exp_d);
        check("sticky", 1, sticky);
        clr_all = 1'b1;
        cyc(5);
        clr_all = 1'b0;
        check("sticky", 0, sticky);
    endtask : t_stop_and_clear
    task automatic t_resume();
        wait_state(state_error_stopped, 4);
        stop_on_mismatch_en = 1'b0;
        cyc(3);
        resume = 1'b1;
        cyc(5);
        resume = 1'b0;
        wait_state(state_done, 300);
        check("mismatch_q", 1, mm);
        check("fail_addr_q", 1, f_addr);
    endtask : t_resume
    task automatic t_read_error();
        stop_on_mismatch_en = 1'b1;
        rerun();
        wait_state(state_retest, 100);
        // Heal the fault before the retest read is taken
        flip = 1'b0;
        wait_state(state_error_stopped, 4);
        check("read_error_q", 1, rd_err);
        check("write_error_q", 0, wr_err);
    endtask : t_read_error
    task automatic t_sync_reset();
        flip = 1'b0;
        gen_sync_reset = 1'b1;
        cyc(4);
        check("gen_state_out", state_start, st);
        check("sticky", 0, sticky);
        gen_sync_reset = 1'b0;
        wait_state(state_write, 10);
        wait_state(state_done, 200);
        cyc(2);
        check("mismatch_q", 0, mm);
    endtask : t_sync_reset
    // ==========================================================
    // Clock, reset, sequence and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {calib_done, run_gate, gen_sync_reset, gen_rerun, gen_hold} = '0;
        {stop_on_mismatch_en, clr_ns, clr_all, resume, flip, stall} = '0;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        t_gate_and_pass();
        t_hold();
        t_stop_and_clear();
        t_resume();
        t_read_error();
        t_sync_reset();
        stop_test();
    end
    initial begin
        #50000;
        fail_count++;
        stop_test();
    end
endmodule : memory_traffic_gen_control_test
`default_nettype wire
